// [fwp_regs.vh]
// Opcodes, field positions and reset values of the flash protect block
`ifndef FWP_REGS_VH
`define FWP_REGS_VH
// Write-class opcodes
`define FWP_OPC_PROG_SINGLE 8'h02
`define FWP_OPC_PROG_QUAD_A 8'h32
`define FWP_OPC_PROG_QUAD_B 8'h38
`define FWP_OPC_ERASE_4K_A 8'hD7
`define FWP_OPC_ERASE_4K_B 8'h20
`define FWP_OPC_ERASE_32K 8'h52
`define FWP_OPC_ERASE_64K 8'hD8
`define FWP_OPC_ERASE_ALL_A 8'hC7
`define FWP_OPC_ERASE_ALL_B 8'h60
`define FWP_OPC_WR_STATUS 8'h01
`define FWP_OPC_WR_FUNC 8'h42
`define FWP_OPC_WR_NV_READ 8'h65
`define FWP_OPC_WR_NV_EXT 8'h85
`define FWP_OPC_ROW_ERASE 8'h64
`define FWP_OPC_ROW_PROG 8'h62
`define FWP_OPC_WR_AUTOBOOT 8'h15
// Latch, volatile, read and suspend opcodes
`define FWP_OPC_ARM 8'h06
`define FWP_OPC_DISARM 8'h04
`define FWP_OPC_SET_VREAD_A 8'hC0
`define FWP_OPC_SET_VREAD_B 8'h63
`define FWP_OPC_SET_VEXT 8'h83
`define FWP_OPC_RD_STATUS 8'h05
`define FWP_OPC_RD_FUNC 8'h48
`define FWP_OPC_SUSPEND 8'h75
`define FWP_OPC_RESUME 8'h7A
// Status word fields
`define FWP_SW_BUSY 0
`define FWP_SW_LATCH 1
`define FWP_SW_PSEL_LO 2
`define FWP_SW_PSEL_HI 5
`define FWP_SW_QUAD 6
`define FWP_SW_LOCK 7
`define FWP_SW_RST 8'h00
`define FWP_SW_PSEL_RST 4'h0
// Function word fields
`define FWP_FW_RSTDIS 0
`define FWP_FW_PROGRAM_SUSPENDED_FLAG 2
`define FWP_FW_ERASE_SUSPENDED_FLAG 3
`define FWP_FW_RLOCK_LO 4
`define FWP_FW_RLOCK_HI 7
`define FWP_FW_RST 8'h00
// Read parameter field that picks reset on the shared pin
`define FWP_RP_SHARED_RST 7
// Address fields
`define FWP_BLK_HI 20
`define FWP_BLK_LO 16
`define FWP_ROW_HI 9
`define FWP_ROW_LO 8
// Frame byte counts (opcode included)
`define FWP_NB_DATA 3'd2
`define FWP_NB_ADDR 3'd4
`define FWP_NB_MAX 3'd7
// Protect code decode
`define FWP_PCODE_NONE 4'h0
`define FWP_PCODE_NONE_B 4'hF
`define FWP_PCODE_TOP_LAST 4'h5
`define FWP_PCODE_ALL_LAST 4'h9
`define FWP_PCODE_BOT_LAST 4'hE
`define FWP_NUM_BLOCKS 6'h20
`endif

// [fwp_sync.v]
// Two-flop synchroniser for pins entering the system clock domain
`timescale 1ns/10ps
module fwp_sync #(
  parameter W = 1
) (
  // Clock and reset
  input wire clk_sys_i,
  input wire rst_i,
  // Data
  input wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // First stage feeds only the second
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= {W{1'b1}};
      sync_q <= {W{1'b1}};
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule // fwp_sync

// [fwp_spi_shift.v]
// Serial byte shifter: samples serial clock edges, assembles and sends bytes
`timescale 1ns/10ps
module fwp_spi_shift (
  // Clock and reset
  input wire clk_sys_i,
  input wire rst_i,
  // Synchronised serial pins
  input wire sclk_s_i,
  input wire cs_n_s_i,
  input wire si_s_i,
  // Transmit byte
  input wire [7:0] tx_byte_i,
  input wire tx_load_i,
  // Receive side
  output reg [7:0] byte_o,
  output reg byte_vld_o,
  output reg frame_end_o,
  // Serial output
  output reg so_o,
  output reg so_oe_n_o
);
  reg sclk_prev_q;
  reg cs_prev_q;
  reg [2:0] bit_cnt_q;
  reg [6:0] rx_q;
  reg [7:0] tx_q;
  wire rise;
  wire fall;

  // Edges of the sampled serial clock
  assign rise = sclk_s_i & ~sclk_prev_q & ~cs_n_s_i;
  assign fall = ~sclk_s_i & sclk_prev_q & ~cs_n_s_i;

  // Shift in on rising edges, out on falling edges
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
      bit_cnt_q <= 3'h0;
      rx_q <= 7'h00;
      tx_q <= 8'h00;
      byte_o <= 8'h00;
      byte_vld_o <= 1'b0;
      frame_end_o <= 1'b0;
      so_o <= 1'b0;
      so_oe_n_o <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_s_i;
      cs_prev_q <= cs_n_s_i;
      byte_vld_o <= 1'b0;
      frame_end_o <= cs_n_s_i & ~cs_prev_q;
      if (cs_n_s_i) begin
        bit_cnt_q <= 3'h0;
        so_oe_n_o <= 1'b1;
      end else if (rise) begin
        bit_cnt_q <= bit_cnt_q + 3'h1;
        rx_q <= {rx_q[5:0], si_s_i};
        if (bit_cnt_q == 3'h7) begin
          byte_o <= {rx_q, si_s_i};
          byte_vld_o <= 1'b1;
        end
      end else if (fall && !so_oe_n_o) begin
        so_o <= tx_q[7];
        tx_q <= {tx_q[6:0], 1'b0};
      end
      if (tx_load_i) begin
        tx_q <= tx_byte_i;
        so_oe_n_o <= 1'b0;
      end
    end
  end
endmodule // fwp_spi_shift

// [fwp_top.v]
// Write latch, block protect, status and function word logic of a serial flash
//
// Contract
// - Latch clear blocks all write-class instructions
// - Arm command sets the write latch
// - Volatile read settings ignore the latch
// - Disarm command clears the write latch
// - Finished write, program or erase clears latch
// - Programs and 4K erase need the latch
// - Block and full erases need the latch
// - Status, function, read-param writes need latch
// - Ext-param, row, autoboot writes need latch
// - Protected target blocks program and erase
// - Codes 1-5 top blocks, 6-9 all
// - Codes 10-14 bottom blocks, 15 none
// - Full erase only with all protect bits zero
// - Lock plus low protect pin freezes status while quad is off
// - Otherwise status word writes are accepted
// - Quad bit turns aux pins into data
// - Program suspend sets flag, resume clears
// - Erase suspend sets flag, resume clears
// - Row locks start zero, one-way to one
// - Reset-disable bit one-way, moves reset pin
// - Only arm and disarm alter latch directly
// - Only status write updates protect cells
`timescale 1ns/10ps
`include "fwp_regs.vh"
module fwp_top #(
  parameter RSTDIS_DEFAULT = 1'b0
) (
  // Clock and reset
  input wire clk_sys_i,
  input wire rst_i,
  // Serial link pins
  input wire sclk_i,
  input wire cs_n_i,
  input wire si_i,
  output wire so_o,
  output wire so_oe_n_o,
  // Auxiliary pins
  input wire wp_io2_i,
  input wire hold_io3_i,
  input wire rst_ded_n_i,
  // Array engine
  output reg op_start_o,
  output reg [7:0] op_code_o,
  output reg [23:0] op_addr_o,
  output reg suspend_o,
  output reg resume_o,
  input wire op_done_i,
  // Register views and pin functions
  output reg [7:0] status_word_o,
  output reg [7:0] function_control_word_o,
  output reg [7:0] read_param_o,
  output reg [7:0] ext_read_param_o,
  output reg hold_o,
  output reg pin_reset_o
);
  // Array operation states
  localparam [1:0] OP_IDLE = 2'd0;
  localparam [1:0] OP_RUN = 2'd1;
  localparam [1:0] OP_SUSP = 2'd2;

  reg [1:0] op_state_q;
  reg op_erase_q;
  reg write_latch_q;
  reg [3:0] protect_sel_q;
  reg quad_pins_on_q;
  reg status_lock_q;
  reg program_suspended_flag_q;
  reg erase_suspended_flag_q;
  reg [3:0] row_lock_q;
  reg rst_dis_q;
  reg [7:0] vread_q;
  reg [7:0] vext_q;
  reg [7:0] opcode_q;
  reg [23:0] addr_q;
  reg [7:0] data_q;
  reg [2:0] bcnt_q;
  reg rd_status_q;
  reg rd_func_q;
  reg tx_load;
  reg [7:0] tx_byte;
  wire sclk_s;
  wire cs_n_s;
  wire si_s;
  wire wp_s;
  wire hold_s;
  wire rst_ded_s;
  wire [7:0] rx_byte;
  wire rx_vld;
  wire frame_end;
  wire [7:0] status_now;
  wire [7:0] func_now;
  wire wp_low;
  wire status_frozen;
  wire [4:0] blk;
  wire [1:0] row;
  wire busy;
  wire shared_is_reset;

  // Every pin passes two flops before use
  fwp_sync #(
    .W(6)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .d_i({sclk_i, cs_n_i, si_i, wp_io2_i, hold_io3_i, rst_ded_n_i}),
    .q_o({sclk_s, cs_n_s, si_s, wp_s, hold_s, rst_ded_s})
  );

  // Byte assembly and serial output
  fwp_spi_shift u_shift (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .sclk_s_i(sclk_s),
    .cs_n_s_i(cs_n_s),
    .si_s_i(si_s),
    .tx_byte_i(tx_byte),
    .tx_load_i(tx_load),
    .byte_o(rx_byte),
    .byte_vld_o(rx_vld),
    .frame_end_o(frame_end),
    .so_o(so_o),
    .so_oe_n_o(so_oe_n_o)
  );

  // Protect code against a 64 KB block number
  function prot_hit;
    input [3:0] code;
    input [4:0] b;
    reg [5:0] n;
    begin
      prot_hit = 1'b0;
      n = 6'h00;
      if (code == `FWP_PCODE_NONE || code == `FWP_PCODE_NONE_B) begin
        prot_hit = 1'b0;
      end else if (code <= `FWP_PCODE_TOP_LAST) begin
        n = 6'h01 << (code - 4'h1);
        prot_hit = ({1'b0, b} >= (`FWP_NUM_BLOCKS - n));
      end else if (code <= `FWP_PCODE_ALL_LAST) begin
        prot_hit = 1'b1;
      end else begin
        n = 6'h01 << (`FWP_PCODE_BOT_LAST - code);
        prot_hit = ({1'b0, b} < n);
      end
    end
  endfunction

  // Write-class instructions handed to the array engine
  function is_array_op;
    input [7:0] op;
    begin
      case (op)
        `FWP_OPC_PROG_SINGLE, `FWP_OPC_PROG_QUAD_A, `FWP_OPC_PROG_QUAD_B,
        `FWP_OPC_ERASE_4K_A, `FWP_OPC_ERASE_4K_B: is_array_op = 1'b1;
        `FWP_OPC_ERASE_32K, `FWP_OPC_ERASE_64K,
        `FWP_OPC_ERASE_ALL_A, `FWP_OPC_ERASE_ALL_B: is_array_op = 1'b1;
        `FWP_OPC_WR_NV_READ: is_array_op = 1'b1;
        `FWP_OPC_WR_NV_EXT, `FWP_OPC_ROW_ERASE, `FWP_OPC_ROW_PROG,
        `FWP_OPC_WR_AUTOBOOT: is_array_op = 1'b1;
        default: is_array_op = 1'b0;
      endcase
    end
  endfunction

  // Erase-type instructions, for the suspend flag choice
  function is_erase_op;
    input [7:0] op;
    begin
      case (op)
        `FWP_OPC_ERASE_4K_A, `FWP_OPC_ERASE_4K_B, `FWP_OPC_ERASE_32K,
        `FWP_OPC_ERASE_64K, `FWP_OPC_ERASE_ALL_A, `FWP_OPC_ERASE_ALL_B,
        `FWP_OPC_ROW_ERASE: is_erase_op = 1'b1;
        default: is_erase_op = 1'b0;
      endcase
    end
  endfunction

  // Whole-array erase opcodes
  function is_full_erase;
    input [7:0] op;
    begin
      is_full_erase = (op == `FWP_OPC_ERASE_ALL_A) || (op == `FWP_OPC_ERASE_ALL_B);
    end
  endfunction

  // Live views of both register words
  assign busy = (op_state_q == OP_RUN);
  assign status_now = {status_lock_q, quad_pins_on_q, protect_sel_q, write_latch_q, busy};
  assign func_now = {row_lock_q, erase_suspended_flag_q, program_suspended_flag_q, 1'b0, rst_dis_q};

  // Protect pin counts only while the aux pin is not a data line
  assign wp_low = ~quad_pins_on_q & ~wp_s;
  assign status_frozen = status_lock_q & wp_low;
  assign blk = addr_q[`FWP_BLK_HI:`FWP_BLK_LO];
  assign row = addr_q[`FWP_ROW_HI:`FWP_ROW_LO];
  assign shared_is_reset = rst_dis_q & vread_q[`FWP_RP_SHARED_RST];

  // Byte sent back while a register read is open
  always @* begin
    tx_load = 1'b0;
    tx_byte = 8'h00;
    if (rx_vld) begin
      if (bcnt_q == 3'h0) begin
        tx_load = (rx_byte == `FWP_OPC_RD_STATUS) || (rx_byte == `FWP_OPC_RD_FUNC);
        tx_byte = (rx_byte == `FWP_OPC_RD_FUNC) ? func_now : status_now;
      end else begin
        tx_load = rd_status_q | rd_func_q;
        tx_byte = rd_func_q ? func_now : status_now;
      end
    end
  end

  // Frame capture: opcode, three address bytes, first data byte
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      opcode_q <= 8'h00;
      addr_q <= 24'h000000;
      data_q <= 8'h00;
      bcnt_q <= 3'h0;
      rd_status_q <= 1'b0;
      rd_func_q <= 1'b0;
    end else if (frame_end) begin
      bcnt_q <= 3'h0;
      rd_status_q <= 1'b0;
      rd_func_q <= 1'b0;
    end else if (rx_vld) begin
      if (bcnt_q != `FWP_NB_MAX) begin
        bcnt_q <= bcnt_q + 3'h1;
      end
      if (bcnt_q == 3'h0) begin
        opcode_q <= rx_byte;
        rd_status_q <= (rx_byte == `FWP_OPC_RD_STATUS);
        rd_func_q <= (rx_byte == `FWP_OPC_RD_FUNC);
      end
      if (bcnt_q == 3'h1) begin
        data_q <= rx_byte;
      end
      if (bcnt_q != 3'h0 && bcnt_q < `FWP_NB_ADDR) begin
        addr_q <= {addr_q[15:0], rx_byte};
      end
    end
  end

  // Register state, latch and operation sequencing at frame end
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      op_state_q <= OP_IDLE;
      op_erase_q <= 1'b0;
      write_latch_q <= 1'b0;
      protect_sel_q <= `FWP_SW_PSEL_RST;
      quad_pins_on_q <= 1'b0;
      status_lock_q <= 1'b0;
      program_suspended_flag_q <= 1'b0;
      erase_suspended_flag_q <= 1'b0;
      row_lock_q <= 4'h0;
      rst_dis_q <= RSTDIS_DEFAULT;
      vread_q <= 8'h00;
      vext_q <= 8'h00;
      op_start_o <= 1'b0;
      op_code_o <= 8'h00;
      op_addr_o <= 24'h000000;
      suspend_o <= 1'b0;
      resume_o <= 1'b0;
    end else begin
      op_start_o <= 1'b0;
      suspend_o <= 1'b0;
      resume_o <= 1'b0;
      // Completion of an engine operation
      if (op_done_i && op_state_q == OP_RUN) begin
        op_state_q <= OP_IDLE;
        write_latch_q <= 1'b0;
      end
      if (frame_end && bcnt_q != 3'h0) begin
        case (opcode_q)
          `FWP_OPC_ARM: begin
            if (!busy) begin
              write_latch_q <= 1'b1;
            end
          end
          `FWP_OPC_DISARM: begin
            if (!busy) begin
              write_latch_q <= 1'b0;
            end
          end
          `FWP_OPC_SET_VREAD_A, `FWP_OPC_SET_VREAD_B: begin
            if (!busy && bcnt_q >= `FWP_NB_DATA) begin
              vread_q <= data_q;
            end
          end
          `FWP_OPC_SET_VEXT: begin
            if (!busy && bcnt_q >= `FWP_NB_DATA) begin
              vext_q <= data_q;
            end
          end
          `FWP_OPC_WR_STATUS: begin
            // Refused write leaves cells and latch alone
            if (write_latch_q && !busy && !status_frozen && bcnt_q >= `FWP_NB_DATA) begin
              status_lock_q <= data_q[`FWP_SW_LOCK];
              quad_pins_on_q <= data_q[`FWP_SW_QUAD];
              protect_sel_q <= data_q[`FWP_SW_PSEL_HI:`FWP_SW_PSEL_LO];
              write_latch_q <= 1'b0;
            end
          end
          `FWP_OPC_WR_FUNC: begin
            if (write_latch_q && !busy && bcnt_q >= `FWP_NB_DATA) begin
              row_lock_q <= row_lock_q | data_q[`FWP_FW_RLOCK_HI:`FWP_FW_RLOCK_LO];
              rst_dis_q <= rst_dis_q | data_q[`FWP_FW_RSTDIS];
              write_latch_q <= 1'b0;
            end
          end
          `FWP_OPC_SUSPEND: begin
            if (op_state_q == OP_RUN && !op_done_i) begin
              op_state_q <= OP_SUSP;
              suspend_o <= 1'b1;
              program_suspended_flag_q <= ~op_erase_q;
              erase_suspended_flag_q <= op_erase_q;
            end
          end
          `FWP_OPC_RESUME: begin
            if (op_state_q == OP_SUSP) begin
              op_state_q <= OP_RUN;
              resume_o <= 1'b1;
              program_suspended_flag_q <= 1'b0;
              erase_suspended_flag_q <= 1'b0;
            end
          end
          default: begin
            // Array and non-volatile parameter operations
            if (is_array_op(opcode_q) && write_latch_q && op_state_q == OP_IDLE) begin
              if (is_full_erase(opcode_q)) begin
                if (protect_sel_q == `FWP_PCODE_NONE) begin
                  op_start_o <= 1'b1;
                  op_code_o <= opcode_q;
                  op_addr_o <= 24'h000000;
                  op_state_q <= OP_RUN;
                  op_erase_q <= 1'b1;
                end
              end else if (bcnt_q >= `FWP_NB_ADDR) begin
                if (opcode_q == `FWP_OPC_ROW_PROG || opcode_q == `FWP_OPC_ROW_ERASE) begin
                  if (!row_lock_q[row]) begin
                    op_start_o <= 1'b1;
                    op_code_o <= opcode_q;
                    op_addr_o <= addr_q;
                    op_state_q <= OP_RUN;
                    op_erase_q <= is_erase_op(opcode_q);
                  end
                end else if (opcode_q == `FWP_OPC_WR_NV_READ || opcode_q == `FWP_OPC_WR_NV_EXT ||
                             opcode_q == `FWP_OPC_WR_AUTOBOOT || !prot_hit(protect_sel_q, blk)) begin
                  op_start_o <= 1'b1;
                  op_code_o <= opcode_q;
                  op_addr_o <= addr_q;
                  op_state_q <= OP_RUN;
                  op_erase_q <= is_erase_op(opcode_q);
                end
              end
            end
          end
        endcase
      end
    end
  end

  // Registered register views and aux pin functions
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      status_word_o <= `FWP_SW_RST;
      function_control_word_o <= `FWP_FW_RST;
      read_param_o <= 8'h00;
      ext_read_param_o <= 8'h00;
      hold_o <= 1'b0;
      pin_reset_o <= 1'b0;
    end else begin
      status_word_o <= status_now;
      function_control_word_o <= func_now;
      read_param_o <= vread_q;
      ext_read_param_o <= vext_q;
      hold_o <= ~quad_pins_on_q & ~shared_is_reset & ~hold_s;
      if (rst_dis_q) begin
        pin_reset_o <= ~quad_pins_on_q & shared_is_reset & ~hold_s;
      end else begin
        pin_reset_o <= ~rst_ded_s;
      end
    end
  end
endmodule // fwp_top

// [fwp_host_model.sv]
// Serial host model that frames instruction bytes on the link pins
`timescale 1ns/10ps
module fwp_host_model (
  // Link pins driven by the host
  output logic sclk_o,
  output logic cs_n_o,
  output logic si_o,
  // Link pin read back
  input wire logic so_i
);
  // Idle link: clock low, chip select high
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b1;
  end
  // Send the top n bytes of v MSB first, mode 0, 125 ns clock; rd keeps the last byte seen
  task automatic xfer(input integer n, input logic [39:0] v, output logic [7:0] rd);
    rd = 8'h00;
    cs_n_o = 1'b0;
    for (int i = 0; i < n * 8; i++) begin
      si_o = v[39 - i];
      #62.5 sclk_o = 1'b1;
      rd = {rd[6:0], so_i};
      #62.5 sclk_o = 1'b0;
    end
    si_o = ~si_o; // Released line shows the inverse of its last bit
    #31.25 cs_n_o = 1'b1;
    #62.5;
  endtask
endmodule // fwp_host_model

// [fwp_top_checker.sv]
// Port assertions for the flash protect block
`timescale 1ns/10ps
module fwp_top_checker (
  // Clock and reset
  input wire clk_sys_i,
  input wire rst_i,
  // Pins
  input wire wp_io2_i,
  input wire hold_o,
  // Array engine
  input wire op_start_o,
  input wire [7:0] op_code_o,
  input wire [23:0] op_addr_o,
  input wire suspend_o,
  input wire resume_o,
  // Register views
  input wire [7:0] status_word_o,
  input wire [7:0] function_control_word_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // Block protected under a protect code
  function automatic logic prot(input logic [3:0] c, input logic [5:0] b);
    if (c == 4'h0 || c == 4'hF) return 1'b0;
    if (c <= 4'h5) return b >= 6'h20 - (6'h01 << (c - 4'h1));
    if (c <= 4'h9) return 1'b1;
    return b < (6'h01 << (4'hE - c));
  endfunction
  // Opcode classes and fields
  wire ers_all = op_code_o == 8'hC7 || op_code_o == 8'h60;
  wire arr = op_code_o inside {8'h02, 8'h32, 8'h38, 8'hD7, 8'h20, 8'h52, 8'hD8};
  wire [1:0] sus = function_control_word_o[3:2];
  // Hardware lock held long enough to pass the pin synchroniser
  sequence s_hw_lock;
    (status_word_o[7] && !status_word_o[6] && !wp_io2_i) [*6];
  endsequence
  // Running operation finished, not suspended
  sequence s_op_end;
    $fell(status_word_o[0]) && sus == 2'h0 && !suspend_o && !$past(suspend_o);
  endsequence
  AST_START_LATCH: assert property (op_start_o |-> status_word_o[1])
    else $error("operation started with latch clear");
  AST_START_UNPROT: assert property (op_start_o && arr |-> !prot(status_word_o[5:2], {1'b0, op_addr_o[20:16]}))
    else $error("operation started in protected block");
  AST_FULL_ERASE: assert property (op_start_o && ers_all |-> status_word_o[5:2] == 4'h0)
    else $error("full erase started with protect code set");
  AST_LATCH_END: assert property (s_op_end |-> ##[0:2] !status_word_o[1])
    else $error("latch kept after operation end");
  AST_HW_LOCK: assert property (s_hw_lock |=> $stable(status_word_o[7:2]))
    else $error("locked status bits changed");
  AST_ROW_ONEWAY: assert property (($past(function_control_word_o[7:4]) & ~function_control_word_o[7:4]) == 4'h0)
    else $error("row lock returned to zero");
  AST_RSTDIS_ONEWAY: assert property ($past(function_control_word_o[0]) |-> function_control_word_o[0])
    else $error("reset disable returned to zero");
  AST_RESERVED: assert property (function_control_word_o[1] == 1'b0)
    else $error("reserved bit set");
  AST_SUSPEND_FLAG: assert property (suspend_o |-> ##[0:2] sus != 2'h0)
    else $error("suspend without flag");
  AST_RESUME_FLAG: assert property (resume_o |-> ##[0:2] sus == 2'h0)
    else $error("resume kept flag");
  AST_QUAD_NO_HOLD: assert property (status_word_o[6] && $past(status_word_o[6]) |-> !hold_o)
    else $error("hold active with quad on");
endmodule // fwp_top_checker
bind fwp_top fwp_top_checker u_fwp_top_checker (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .wp_io2_i(wp_io2_i),
  .hold_o(hold_o), .op_start_o(op_start_o), .op_code_o(op_code_o), .op_addr_o(op_addr_o), .suspend_o(suspend_o),
  .resume_o(resume_o), .status_word_o(status_word_o), .function_control_word_o(function_control_word_o));

// [tb_top.sv]
// Self-checking bench for the flash protect block
`timescale 1ns/10ps
module tb_top;
  logic clk_sys_i, rst_i, op_done_i, wp_io2_i, hold_io3_i, rst_ded_n_i;
  wire sclk, cs_n, si, so_o, so_oe_n_o, op_start_o, suspend_o, resume_o, hold_o, pin_reset_o;
  wire [7:0] op_code_o, status_word_o, function_control_word_o, read_param_o, ext_read_param_o;
  wire [23:0] op_addr_o;
  integer fail_count = 0, n_tests = 0, seed = 41, st_cnt = 0, su_cnt = 0, re_cnt = 0, c;
  logic m_latch, m_busy, m_quad, m_lock, m_susp;
  logic [3:0] m_code;
  logic [7:0] m_fw, m_rp, m_erp, m_op, rd;
  logic [7:0] wc_ops [16] = '{8'h01, 8'h42, 8'h02, 8'h32, 8'h38, 8'hD7, 8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60,
    8'h65, 8'h85, 8'h64, 8'h62, 8'h15};
  // Device under test and serial host; a released data line reads inverted
  fwp_top #(.RSTDIS_DEFAULT(1'b0)) u_fwp_top (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .si_i(si), .so_o(so_o), .so_oe_n_o(so_oe_n_o), .wp_io2_i(wp_io2_i), .hold_io3_i(hold_io3_i),
    .rst_ded_n_i(rst_ded_n_i), .op_start_o(op_start_o), .op_code_o(op_code_o), .op_addr_o(op_addr_o),
    .suspend_o(suspend_o), .resume_o(resume_o), .op_done_i(op_done_i), .status_word_o(status_word_o),
    .function_control_word_o(function_control_word_o), .read_param_o(read_param_o),
    .ext_read_param_o(ext_read_param_o), .hold_o(hold_o), .pin_reset_o(pin_reset_o));
  fwp_host_model u_fwp_host_model (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so_oe_n_o ? ~so_o : so_o));
  // System clock, 4 ns period
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  // Pulse counters on the engine outputs
  always @(posedge clk_sys_i) begin
    if (op_start_o === 1'b1) st_cnt <= st_cnt + 1;
    if (suspend_o === 1'b1) su_cnt <= su_cnt + 1;
    if (resume_o === 1'b1) re_cnt <= re_cnt + 1;
  end
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Model of the protect decode
  function automatic logic prot(input logic [3:0] c, input logic [5:0] b);
    if (c == 4'h0 || c == 4'hF) return 1'b0;
    if (c <= 4'h5) return b >= 6'h20 - (6'h01 << (c - 4'h1));
    if (c <= 4'h9) return 1'b1;
    return b < (6'h01 << (4'hE - c));
  endfunction
  // Engine reports completion
  task automatic done();
    @(posedge clk_sys_i) op_done_i <= 1'b1;
    @(posedge clk_sys_i) op_done_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    m_busy = 1'b0;
    m_latch = 1'b0;
  endtask
  // One instruction frame, model step and comparison of every result
  task automatic send(input logic [7:0] op, input logic [31:0] p, input logic keep);
    integer s0, n;
    logic st, pg;
    s0 = st_cnt;
    st = 1'b0;
    n = op inside {8'h06, 8'h04, 8'h75, 8'h7A, 8'hC7, 8'h60} ? 1 : op inside {8'h02, 8'h32, 8'h38, 8'h62} ? 5 :
      op inside {8'hD7, 8'h20, 8'h52, 8'hD8, 8'h64, 8'h65, 8'h85, 8'h15} ? 4 : 2;
    u_fwp_host_model.xfer(n, {op, p}, rd);
    repeat (12) @(posedge clk_sys_i);
    if (op == 8'h06 && !m_busy) m_latch = 1'b1;
    if (op == 8'h04 && !m_busy) m_latch = 1'b0;
    if (op inside {8'hC0, 8'h63}) m_rp = p[31:24];
    if (op == 8'h83) m_erp = p[31:24];
    if (op == 8'h75 && m_busy) m_susp = 1'b1;
    if (op == 8'h7A) m_susp = 1'b0;
    if (m_latch && !m_busy && op inside {wc_ops}) begin
      if (op == 8'h01 && !(m_lock && !m_quad && !wp_io2_i)) begin
        {m_lock, m_quad, m_code} = p[31:26];
        m_latch = 1'b0;
      end else if (op == 8'h42) begin
        m_fw = m_fw | (p[31:24] & 8'hF1);
        m_latch = 1'b0;
      end else if (op inside {8'hC7, 8'h60}) st = m_code === 4'h0;
      else if (op inside {8'h64, 8'h62}) st = !m_fw[4 + p[17:16]];
      else if (op inside {8'h65, 8'h85, 8'h15}) st = 1'b1;
      else if (op != 8'h01) st = !prot(m_code, {1'b0, p[28:24]});
    end
    check(st_cnt - s0, st);
    if (st) begin
      m_busy = 1'b1;
      m_op = op;
      check(op_code_o, op);
      check(op_addr_o, op inside {8'hC7, 8'h60} ? 24'h0 : p[31:8]);
      if (!keep) done();
    end
    pg = m_op inside {8'h02, 8'h32, 8'h38, 8'h62};
    if (op == 8'h05) check(rd, {m_lock, m_quad, m_code, m_latch, m_busy});
    if (op == 8'h48) check(rd, m_fw);
    check(status_word_o, {m_lock, m_quad, m_code, m_latch, m_busy & !m_susp});
    check(function_control_word_o, m_fw | {4'h0, m_susp & !pg, m_susp & pg, 2'h0});
    check({read_param_o, ext_read_param_o}, {m_rp, m_erp});
  endtask
  // Drive the shared and dedicated pins and compare their functions
  task automatic pins(input logic h, input logic r);
    logic sh;
    @(posedge clk_sys_i) {hold_io3_i, rst_ded_n_i} <= {h, r};
    repeat (8) @(posedge clk_sys_i);
    sh = m_fw[0] && m_rp[7] && !m_quad;
    check(hold_o, !m_quad && !h && !sh);
    check(pin_reset_o, (!r && !m_fw[0]) || (sh && !h));
    @(posedge clk_sys_i) {hold_io3_i, rst_ded_n_i} <= 2'h3;
    repeat (8) @(posedge clk_sys_i);
  endtask
  task automatic tend(input string s);
    $display("test %s done at %0t", s, $time);
  endtask
  // Verdict and end of run
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Cut a hang short
  initial begin
    #420000;
    fail_count++;
    finish_test();
  end
  // Main sequence
  initial begin
    {rst_i, op_done_i, wp_io2_i, hold_io3_i, rst_ded_n_i} = 5'h17;
    {m_latch, m_busy, m_quad, m_lock, m_susp, m_code} = 9'h000;
    {m_fw, m_rp, m_erp, m_op} = 32'h0;
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    send(8'h05, 32'h0, 1'b0);
    send(8'h48, 32'h0, 1'b0);
    pins(1'b0, 1'b0);
    tend("reset");
    for (c = 0; c < 16; c++) send(wc_ops[c], $random(seed), 1'b0);
    tend("refuse");
    for (c = 2; c < 16; c++) begin
      send(8'h06, 32'h0, 1'b0);
      send(wc_ops[c], $random(seed), 1'b0);
    end
    tend("armed");
    send(8'hC0, $random(seed), 1'b0);
    send(8'h63, $random(seed), 1'b0);
    send(8'h83, $random(seed), 1'b0);
    send(8'h06, 32'h0, 1'b0);
    send(8'h04, 32'h0, 1'b0);
    tend("volatile");
    for (c = 0; c < 17; c++) begin
      send(8'h06, 32'h0, 1'b0);
      send(8'h01, {2'h0, c[3:0], 26'h0}, 1'b0);
      send(8'h06, 32'h0, 1'b0);
      send(c[0] ? 8'hD8 : 8'h20, $random(seed), 1'b0);
      send(8'h06, 32'h0, 1'b0);
      send(8'hC7, 32'h0, 1'b0);
    end
    tend("protect");
    send(8'h06, 32'h0, 1'b0);
    send(8'h01, 32'h8C00_0000, 1'b0);
    @(posedge clk_sys_i) wp_io2_i <= 1'b0;
    send(8'h06, 32'h0, 1'b0);
    send(8'h01, 32'h0, 1'b0);
    @(posedge clk_sys_i) wp_io2_i <= 1'b1;
    send(8'h01, 32'h0, 1'b0);
    tend("lock");
    for (c = 0; c < 2; c++) begin
      send(8'h06, 32'h0, 1'b0);
      send(c[0] ? 8'hD8 : 8'h02, $random(seed), 1'b1);
      send(8'h04, 32'h0, 1'b0);
      send(8'h75, 32'h0, 1'b0);
      check(su_cnt, c + 1);
      send(8'h7A, 32'h0, 1'b0);
      check(re_cnt, c + 1);
      done();
    end
    tend("suspend");
    send(8'h06, 32'h0, 1'b0);
    send(8'h42, 32'hFF00_0000, 1'b0);
    send(8'h06, 32'h0, 1'b0);
    send(8'h42, 32'h0, 1'b0);
    send(8'h06, 32'h0, 1'b0);
    send(8'h62, 32'h0000_0200, 1'b0);
    send(8'h04, 32'h0, 1'b0);
    send(8'hC0, 32'h8000_0000, 1'b0);
    pins(1'b0, 1'b1);
    pins(1'b1, 1'b0);
    send(8'h06, 32'h0, 1'b0);
    send(8'h01, 32'h4000_0000, 1'b0);
    pins(1'b0, 1'b0);
    send(8'h06, 32'h0, 1'b0);
    send(8'h01, 32'h0, 1'b0);
    send(8'h05, 32'h0, 1'b0);
    send(8'h48, 32'h0, 1'b0);
    tend("otp_pins");
    finish_test();
  end
endmodule // tb_top
